//--- flash_user_config_params.svh
// How it works
// - Core held in reset 0xff minus delay field slow ticks after power-on.
// - Reset, filter and detector enables, bits 14..12, are active low.
// - Threshold code is 0x0f minus bits 11:8; 1.8 V up to 4.8 V.
// - Detector pulses shorter than 0xff minus count field ticks are ignored.
// - Relocation register bits 30:0 hold the vector table base address.
// - Vector base applies only while relocation enable bit 31 is one.
`ifndef FLASH_USER_CONFIG_PARAMS_SVH
`define FLASH_USER_CONFIG_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////
// Register offsets
`define USER_CFG_OFFSET   8'h20
`define VTOR_OFFSET       8'h24
`define STATUS_OFFSET     8'h28

////////////////////////////////////////////////////////////////////////////
// Reset values
`define USER_CFG_RESET    32'hffffffff
`define VTOR_RESET        32'h00000000
`define STATUS_RESET      32'h00000000

////////////////////////////////////////////////////////////////////////////
// Field positions
`define RELOC_EN_BIT      31
`define VTOR_BASE_MSB     30
`define ST_CORE_REL_BIT   0
`define ST_UV_SEEN_BIT    1
`define ST_UV_REQ_BIT     2

////////////////////////////////////////////////////////////////////////////
// Counting limits
`define COUNT_FULL        8'hff
`define LEVEL_FULL        4'hf

`endif

//--- flash_user_config_pkg.sv
package flash_user_config_pkg;

  // User settings word, msb first
  typedef struct packed {
    logic [7:0] reserved_hi;
    logic [7:0] release_delay;
    logic       reserved_b15;
    logic       undervolt_reset_enable_n;
    logic       undervolt_filter_enable_n;
    logic       undervolt_detect_enable_n;
    logic [3:0] undervolt_level_select;
    logic [7:0] undervolt_filter_count;
  } user_cfg_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Power-up sequence
  typedef enum logic [2:0] {
    ST_LOAD  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } boot_state_t;

endpackage

//--- flash_user_config_regs.sv
`timescale 1ns/1ps
`include "flash_user_config_params.svh"

module flash_user_config_regs #(
  parameter logic [31:0] DEFAULT_VECTOR_BASE = 32'h00000000
) (
  // Clock and reset
  input  wire logic                               clk_sys,
  input  wire logic                               rstn,
  // Register port
  input  wire flash_user_config_pkg::reg_req_t    reg_req,
  output logic [31:0]                             reg_rdata,
  // Nonvolatile settings word, same clock
  input  wire logic [31:0]                        nv_user_word,
  // Slow oscillator and detector pins
  input  wire logic                               slow_internal_oscillator,
  input  wire logic                               undervolt_detect_raw,
  // Core reset and supervisor controls
  output logic                                    core_reset_n,
  output logic                                    undervoltage_reset,
  output logic                                    undervolt_detect_on,
  output logic [3:0]                              undervolt_level_code,
  // Vector fetch base
  output logic [31:0]                             vector_fetch_base,
  output logic                                    vector_relocate_active
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  flash_user_config_pkg::user_cfg_t    user_ff;
  flash_user_config_pkg::boot_state_t  state_ff;
  logic [31:0] vtor_ff;
  logic [31:0] rdata_ff;
  logic [7:0]  delay_cnt_ff;
  logic [7:0]  uv_cnt_ff;
  logic        osc_meta_ff;
  logic        osc_sync_ff;
  logic        osc_prev_ff;
  logic        uv_meta_ff;
  logic        uv_sync_ff;
  logic        uv_filt_ff;
  logic        core_rel_ff;
  logic        uv_req_ff;
  logic        uv_on_ff;
  logic [3:0]  level_ff;
  logic [31:0] vbase_ff;
  logic        vrel_ff;
  logic        osc_tick;
  logic [7:0]  delay_target;
  logic [7:0]  filter_width;
  logic        filter_bypass;
  logic        uv_active;
  logic [31:0] status_word;

  assign osc_tick      = osc_sync_ff & ~osc_prev_ff;
  assign delay_target  = `COUNT_FULL - user_ff.release_delay;
  assign filter_width  = `COUNT_FULL - user_ff.undervolt_filter_count;
  assign filter_bypass = user_ff.undervolt_filter_enable_n ||
                         (filter_width == 8'h00);
  assign uv_active     = ~user_ff.undervolt_detect_enable_n & uv_sync_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage never feeds logic
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end else begin
      osc_meta_ff <= slow_internal_oscillator;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      uv_meta_ff <= 1'b0;
      uv_sync_ff <= 1'b0;
    end else begin
      uv_meta_ff <= undervolt_detect_raw;
      uv_sync_ff <= uv_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User settings: loaded once after reset, never written by software
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      user_ff <= `USER_CFG_RESET;
    end else if (state_ff == flash_user_config_pkg::ST_LOAD) begin
      user_ff <= nv_user_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-up release sequence
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_ff     <= flash_user_config_pkg::ST_LOAD;
      delay_cnt_ff <= 8'h00;
      core_rel_ff  <= 1'b0;
    end else begin
      case (state_ff)
        flash_user_config_pkg::ST_LOAD: begin
          state_ff     <= flash_user_config_pkg::ST_DELAY;
          delay_cnt_ff <= 8'h00;
        end
        flash_user_config_pkg::ST_DELAY: begin
          if (delay_cnt_ff == delay_target) begin
            state_ff    <= flash_user_config_pkg::ST_RUN;
            core_rel_ff <= 1'b1;
          end else if (osc_tick) begin
            delay_cnt_ff <= delay_cnt_ff + 8'h01;
          end
        end
        flash_user_config_pkg::ST_RUN: begin
          core_rel_ff <= 1'b1;
        end
        default: begin
          state_ff <= flash_user_config_pkg::ST_LOAD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector glitch filter; width counts whole oscillator periods
  // Tick phase leaves up to one period of width slack
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      uv_cnt_ff  <= 8'h00;
      uv_filt_ff <= 1'b0;
    end else if (!uv_active) begin
      uv_cnt_ff  <= 8'h00;
      uv_filt_ff <= 1'b0;
    end else begin
      if (osc_tick && uv_cnt_ff != `COUNT_FULL) begin
        uv_cnt_ff <= uv_cnt_ff + 8'h01;
      end
      uv_filt_ff <= filter_bypass || (uv_cnt_ff >= filter_width);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      uv_req_ff <= 1'b0;
      uv_on_ff  <= 1'b0;
      level_ff  <= 4'h0;
    end else begin
      uv_on_ff  <= ~user_ff.undervolt_detect_enable_n;
      uv_req_ff <= uv_filt_ff & ~user_ff.undervolt_reset_enable_n &
                   ~user_ff.undervolt_detect_enable_n;
      level_ff  <= `LEVEL_FULL - user_ff.undervolt_level_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector relocation register; all 32 bits writable
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vtor_ff <= `VTOR_RESET;
    end else if (reg_req.wr && hit(reg_req.addr, `VTOR_OFFSET)) begin
      vtor_ff <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vbase_ff <= DEFAULT_VECTOR_BASE;
      vrel_ff  <= 1'b0;
    end else begin
      vrel_ff <= vtor_ff[`RELOC_EN_BIT];
      if (vtor_ff[`RELOC_EN_BIT]) begin
        vbase_ff <= {1'b0, vtor_ff[`VTOR_BASE_MSB:0]};
      end else begin
        vbase_ff <= DEFAULT_VECTOR_BASE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port; data stands only in the cycle after the strobe
  always_comb begin
    status_word = `STATUS_RESET;
    status_word[`ST_CORE_REL_BIT] = core_rel_ff;
    status_word[`ST_UV_SEEN_BIT]  = uv_filt_ff;
    status_word[`ST_UV_REQ_BIT]   = uv_req_ff;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 32'h00000000;
    end else if (!reg_req.rd) begin
      rdata_ff <= 32'h00000000;
    end else if (hit(reg_req.addr, `USER_CFG_OFFSET)) begin
      rdata_ff <= user_ff;
    end else if (hit(reg_req.addr, `VTOR_OFFSET)) begin
      rdata_ff <= vtor_ff;
    end else if (hit(reg_req.addr, `STATUS_OFFSET)) begin
      rdata_ff <= status_word;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign reg_rdata              = rdata_ff;
  assign core_reset_n           = core_rel_ff;
  assign undervoltage_reset     = uv_req_ff;
  assign undervolt_detect_on    = uv_on_ff;
  assign undervolt_level_code   = level_ff;
  assign vector_fetch_base      = vbase_ff;
  assign vector_relocate_active = vrel_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking chk_cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // Helper: oscillator ticks seen while waiting for release
  logic [8:0] chk_ticks_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chk_ticks_ff <= 9'h000;
    end else if (state_ff == flash_user_config_pkg::ST_LOAD) begin
      chk_ticks_ff <= 9'h000;
    end else if (state_ff == flash_user_config_pkg::ST_DELAY && osc_tick &&
                 delay_cnt_ff != delay_target) begin
      chk_ticks_ff <= chk_ticks_ff + 9'h001;
    end
  end

  a_release_delay_count : assert property (
    $rose(core_reset_n) |-> chk_ticks_ff == {1'b0, delay_target})
    else $error("core released after wrong tick count");

  a_no_delay_release : assert property (
    (state_ff == flash_user_config_pkg::ST_DELAY && delay_target == 8'h00)
    |=> core_reset_n)
    else $error("zero delay did not release core at once");

  a_reset_enable_low : assert property (
    user_ff.undervolt_reset_enable_n |=> !undervoltage_reset)
    else $error("undervoltage reset raised while disabled");

  a_detector_enable_low : assert property (
    (state_ff == flash_user_config_pkg::ST_RUN)
    |=> undervolt_detect_on == !$past(user_ff.undervolt_detect_enable_n))
    else $error("detector enable polarity wrong");

  a_level_inverted : assert property (
    (state_ff == flash_user_config_pkg::ST_RUN) [*2]
    |-> undervolt_level_code == 4'hf - user_ff.undervolt_level_select)
    else $error("threshold code not inverted");

  a_filter_short_pulse : assert property (
    $rose(uv_filt_ff)
    |-> $past(filter_bypass || uv_cnt_ff >= filter_width))
    else $error("detector pulse passed before filter width");

  a_filter_bypass_pass : assert property (
    (uv_active && filter_bypass) |=> uv_filt_ff || !$past(uv_active, 1))
    else $error("unfiltered detector pulse was held back");

  a_user_write_ignored : assert property (
    (reg_req.wr && hit(reg_req.addr, `USER_CFG_OFFSET) &&
     state_ff != flash_user_config_pkg::ST_LOAD) |=> $stable(user_ff))
    else $error("software write changed user settings");

  a_vtor_store : assert property (
    (reg_req.wr && hit(reg_req.addr, `VTOR_OFFSET))
    |=> vtor_ff == $past(reg_req.wdata) ##1
        ($past(vtor_ff[`RELOC_EN_BIT]) ||
         vector_fetch_base == DEFAULT_VECTOR_BASE))
    else $error("relocation register not stored");

  a_vector_gate : assert property (
    vtor_ff[`RELOC_EN_BIT]
    |=> vector_relocate_active &&
        vector_fetch_base == {1'b0, $past(vtor_ff[30:0])})
    else $error("relocated base not applied while enabled");

  a_vector_default : assert property (
    !vtor_ff[`RELOC_EN_BIT]
    |=> !vector_relocate_active && vector_fetch_base == DEFAULT_VECTOR_BASE)
    else $error("vector base applied while relocation disabled");

  a_detect_off_quiet : assert property (
    user_ff.undervolt_detect_enable_n |=> !uv_filt_ff)
    else $error("detector output seen while detector disabled");

  a_read_one_cycle : assert property (
    !reg_req.rd |=> reg_rdata == 32'h00000000)
    else $error("read data stood outside its cycle");

endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] BASE = 32'h00001000;
  logic                            clk_sys;
  logic                            rstn;
  flash_user_config_pkg::reg_req_t reg_req;
  logic [31:0]                     reg_rdata;
  logic [31:0]                     nv_user_word;
  logic                            slow_internal_oscillator;
  logic                            undervolt_detect_raw;
  logic                            core_reset_n;
  logic                            undervoltage_reset;
  logic                            undervolt_detect_on;
  logic [3:0]                      undervolt_level_code;
  logic [31:0]                     vector_fetch_base;
  logic                            vector_relocate_active;
  logic [2:0]                      osc_div;
  logic [31:0]                     seed;
  logic [31:0]                     w;
  logic [31:0]                     v;
  logic [31:0]                     g;
  int                              fails;
  int                              compares;
  int                              c;
  logic [7:0]  dl    [3] = '{8'hff, 8'hf0, 8'he6};
  logic [31:0] det_w [4] = '{32'hffffa0ff, 32'hffffe0ff, 32'hffffb0ff,
                             32'hffff80f8};
  logic        det_e [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

  ////////////////////////////////////////////////////////////////////////////
  flash_user_config_regs #(.DEFAULT_VECTOR_BASE(BASE)) dut (
    .clk_sys                  (clk_sys),
    .rstn                     (rstn),
    .reg_req                  (reg_req),
    .reg_rdata                (reg_rdata),
    .nv_user_word             (nv_user_word),
    .slow_internal_oscillator (slow_internal_oscillator),
    .undervolt_detect_raw     (undervolt_detect_raw),
    .core_reset_n             (core_reset_n),
    .undervoltage_reset       (undervoltage_reset),
    .undervolt_detect_on      (undervolt_detect_on),
    .undervolt_level_code     (undervolt_level_code),
    .vector_fetch_base        (vector_fetch_base),
    .vector_relocate_active   (vector_relocate_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // Slow tick every 8 clocks keeps the long counts short
  always @(posedge clk_sys) begin
    osc_div <= osc_div + 3'h1;
    slow_internal_oscillator <= osc_div[2];
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic [31:0] exp_base(input logic [31:0] r);
    return r[31] ? {1'b0, r[30:0]} : BASE;
  endfunction

  task automatic results();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] gv);
    compares++;
    if (gv !== e) begin
      fails++;
      $display("unexpected %s exp %h got %h", nm, e, gv);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic do_reset(input logic [31:0] word);
    @(posedge clk_sys);
    rstn <= 1'b0;
    nv_user_word <= word;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask

  // Allows sync latency plus one slow period of phase slack
  task automatic core_wait(input int n);
    int k;
    k = 0;
    while (core_reset_n !== 1'b1 && k < 4000) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    if (k >= 4000) begin
      fails++;
      $display("unexpected core_release exp 1 got %b", core_reset_n);
      results();
    end else begin
      chk("core_delay", 32'h1,
          {31'h0, k >= 8 * n - 8 && k <= 8 * n + 12});
    end
  endtask

  task automatic uv_run(input int lim, output int n);
    n = 0;
    @(posedge clk_sys);
    undervolt_detect_raw <= 1'b1;
    while (undervoltage_reset !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    @(posedge clk_sys);
    undervolt_detect_raw <= 1'b0;
    repeat (80) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    reg_req = '0;
    nv_user_word = 32'h0;
    undervolt_detect_raw = 1'b0;
    osc_div = 3'h0;
    slow_internal_oscillator = 1'b0;
    seed = 32'h000044a7;
    fails = 0;
    compares = 0;
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      w = {8'hff, dl[k], 1'b1, seed[14:0]};
      do_reset(w);
      core_wait(8'hff - dl[k]);
      chk("level", {28'h0, 4'hf - w[11:8]},
          {28'h0, undervolt_level_code});
      chk("detect_on", {31'h0, ~w[12]}, {31'h0, undervolt_detect_on});
      rd(8'h20, g);
      chk("user_rd", w, g);
      rd(8'h28, g);
      chk("status", 32'h1, g);
      wr(8'h20, seed ^ 32'h5a5a5a5a);
      rd(8'h20, g);
      chk("user_ro", w, g);
    end
    for (int k = 0; k < 8; k++) begin
      seed = xs(seed);
      v = (k == 0) ? 32'h88000c00 : (k == 1) ? 32'h7fffffff : seed;
      wr(8'h24, v);
      rd(8'h24, g);
      chk("vtor_rd", v, g);
      chk("reloc_act", {31'h0, v[31]},
          {31'h0, vector_relocate_active});
      chk("fetch_base", exp_base(v), vector_fetch_base);
    end
    wr(8'h40, seed);
    rd(8'h40, g);
    chk("unmapped", 32'h0, g);
    for (int k = 0; k < 4; k++) begin
      do_reset(det_w[k]);
      core_wait(0);
      uv_run(20, c);
      chk("uv_fast", {31'h0, det_e[k]}, {31'h0, c < 8});
    end
    // Last setting filters seven slow periods
    uv_run(200, c);
    chk("uv_filter", 32'h1, {31'h0, c >= 48 && c <= 80});
    results();
  end
endmodule
